//--- kbd_mouse_peer.sv
// Keyboard and mouse on the far side of the open-drain lines
module kbd_mouse_peer (
  input wire logic i_kbd_data_low, // Keyboard holds its data line low
  input wire logic i_mouse_data_low, // Mouse holds its data line low
  input wire logic [3:0] i_dut_oe_n, // Device drive enables: kbd_clock_line, kbd_data_line, mclk, mouse_data_line
  output logic [3:0] o_line // Resolved line levels, same order
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pull-ups win unless either side pulls; only the device pulls the clock lines, the peer never does
  always_comb begin
    o_line[0] = i_dut_oe_n[0];
    o_line[1] = i_dut_oe_n[1] & ~i_kbd_data_low;
    o_line[2] = i_dut_oe_n[2];
    o_line[3] = i_dut_oe_n[3] & ~i_mouse_data_low;
  end
endmodule

//--- kbd_mouse_wake_isolation.sv
`include "kbd_wake_map.svh"
module kbd_mouse_wake_isolation
  import kbd_wake_pkg::*;
(
  input wire logic i_clk_sys, // System clock, 100 MHz
  input wire logic i_reset_n, // Main supply reset
  input wire logic i_standby_reset_n, // Standby supply power-on reset
  input wire logic i_main_power_good, // Main supply present, async
  input wire logic [7:0] i_addr, // Register address
  input wire logic [7:0] i_wdata, // Register write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [7:0] o_rdata, // Read data, cycle after strobe
  input wire logic i_kbc_kbd_irq, // Raw controller keyboard irq
  input wire logic i_kbc_mouse_irq, // Raw controller mouse irq
  input wire logic i_kbd_irq_clr, // Clears keyboard irq latch
  input wire logic i_mouse_irq_clr, // Clears mouse irq latch
  output logic o_kbd_irq, // Keyboard irq to host
  output logic o_mouse_irq, // Mouse irq to host
  input wire logic i_kbc_kbd_clock_pull, // Controller pulls kbd clock low
  input wire logic i_kbc_kbd_data_pull, // Controller pulls kbd data low
  input wire logic i_kbc_mouse_clock_pull, // Controller pulls mouse clock low
  input wire logic i_kbc_mouse_data_pull, // Controller pulls mouse data low
  output logic o_kbc_kbd_clock, // Keyboard clock to controller
  output logic o_kbc_kbd_data, // Keyboard data to controller
  output logic o_kbc_mouse_clock, // Mouse clock to controller
  output logic o_kbc_mouse_data, // Mouse data to controller
  output logic o_kbc_reset_n, // Controller reset, low active
  input wire logic i_kbd_clock_line, // Keyboard clock pin level
  input wire logic i_kbd_data_line, // Keyboard data pin level
  input wire logic i_mouse_clock_line, // Mouse clock pin level
  input wire logic i_mouse_data_line, // Mouse data pin level
  output logic o_kbd_clock_line, // Keyboard clock pin drive value
  output logic o_kbd_clock_line_oe_n, // Keyboard clock drive enable
  output logic o_kbd_data_line, // Keyboard data pin drive value
  output logic o_kbd_data_line_oe_n, // Keyboard data drive enable
  output logic o_mouse_clock_line, // Mouse clock pin drive value
  output logic o_mouse_clock_line_oe_n, // Mouse clock drive enable
  output logic o_mouse_data_line, // Mouse data pin drive value
  output logic o_mouse_data_line_oe_n, // Mouse data drive enable
  output logic o_wake_event_out_n, // Wake event, low active
  output logic o_irq // Level interrupt to software
);

  standby_state_t sb_reg; // Standby state
  standby_state_t sb_next; // Next standby state
  main_state_t mn_reg; // Main state
  main_state_t mn_next; // Next main state
  logic wr_ctl; // Write to control register
  logic wr_status; // Write to wake status
  logic kbd_irq_rise; // Raw keyboard irq edge
  logic mouse_irq_rise; // Raw mouse irq edge
  logic [7:0] wake_set; // Wake events this cycle
  logic [7:0] wake_clr; // Status bits cleared by software
  logic wake_active; // Any enabled status set

  // Decoded write strobes shared by both supplies
  assign wr_ctl = i_wr && (i_addr == `OFS_WAKE_CONTROL);
  assign wr_status = i_wr && (i_addr == `OFS_WAKE_STATUS);
  assign wake_clr = wr_status ? i_wdata : `RST_BYTE;

  // Raw irq edges from the controller
  assign kbd_irq_rise = i_kbc_kbd_irq && !mn_reg.kbd_irq_prev;
  assign mouse_irq_rise = i_kbc_mouse_irq && !mn_reg.mouse_irq_prev;

  // Wake events: irq sources only with main power
  always_comb begin
    wake_set = `RST_BYTE;
    // Irq wakes gated by synced main power
    wake_set[`BIT_WAKE_KBD_IRQ] = kbd_irq_rise && sb_reg.pg_sync[1]; // R3 R5
    wake_set[`BIT_WAKE_MOUSE_IRQ] = mouse_irq_rise && sb_reg.pg_sync[1]; // R3 R5
    // Data falling edges, never blocked by isolation
    wake_set[`BIT_WAKE_KBD_DATA] = sb_reg.kd_prev && !sb_reg.kd_sync[1]; // R11 R16
    wake_set[`BIT_WAKE_MOUSE_DATA] = sb_reg.md_prev && !sb_reg.md_sync[1]; // R11 R16
  end

  // Standby next state
  always_comb begin
    sb_next = sb_reg;
    // Two-stage synchronisers for the pins
    sb_next.kd_sync = {sb_reg.kd_sync[0], i_kbd_data_line}; // R16
    sb_next.md_sync = {sb_reg.md_sync[0], i_mouse_data_line}; // R16
    sb_next.kc_sync = {sb_reg.kc_sync[0], i_kbd_clock_line};
    sb_next.mc_sync = {sb_reg.mc_sync[0], i_mouse_clock_line};
    sb_next.pg_sync = {sb_reg.pg_sync[0], i_main_power_good};
    // Edge history from the second stage only
    sb_next.kd_prev = sb_reg.kd_sync[1];
    sb_next.md_prev = sb_reg.md_sync[1];
    // Isolation bits live on standby
    if (wr_ctl) begin
      sb_next.kbd_iso = i_wdata[`BIT_KBD_ISO]; // R8
      sb_next.mouse_iso = i_wdata[`BIT_MOUSE_ISO]; // R8
    end
    // Enables kept on standby
    if (i_wr && (i_addr == `OFS_WAKE_ENABLE)) begin
      sb_next.wake_enable = i_wdata & `WAKE_IMPL_MASK; // R12
    end
    // Global enable
    if (i_wr && (i_addr == `OFS_GLOBAL_ENABLE)) begin
      sb_next.global_wake_enable = i_wdata[0];
    end
    // Sticky status: a new event beats a clear
    sb_next.wake_status = (sb_reg.wake_status & ~wake_clr) | wake_set; // R3
  end

  // Standby registers, cleared only by standby reset
  always_ff @(posedge i_clk_sys or negedge i_standby_reset_n) begin
    if (!i_standby_reset_n) begin
      sb_reg <= '0; // R8 R12
      sb_reg.kd_sync <= 2'h3;
      sb_reg.md_sync <= 2'h3;
      sb_reg.kc_sync <= 2'h3;
      sb_reg.mc_sync <= 2'h3;
      sb_reg.kd_prev <= 1'h1;
      sb_reg.md_prev <= 1'h1;
    end else begin
      sb_reg <= sb_next;
    end
  end

  // Main next state and register read mux
  always_comb begin
    mn_next = mn_reg;
    mn_next.rst_hold = 1'b0;
    mn_next.kbd_irq_prev = i_kbc_kbd_irq;
    mn_next.mouse_irq_prev = i_kbc_mouse_irq;
    // Irq latches set on raw edge, clear wins only alone
    if (i_kbd_irq_clr) begin
      mn_next.kbd_irq_latch = 1'b0;
    end
    if (kbd_irq_rise) begin
      mn_next.kbd_irq_latch = 1'b1;
    end
    if (i_mouse_irq_clr) begin
      mn_next.mouse_irq_latch = 1'b0;
    end
    if (mouse_irq_rise) begin
      mn_next.mouse_irq_latch = 1'b1;
    end
    // Control and soft reset writes
    if (wr_ctl) begin
      mn_next.ctl_misc = i_wdata;
    end
    if (i_wr && (i_addr == `OFS_KBC_SOFT_RESET)) begin
      mn_next.soft_reset_ctl = i_wdata; // R9
    end
    if (i_wr && (i_addr == `OFS_IRQ_MASK)) begin
      mn_next.irq_mask = i_wdata & `WAKE_IMPL_MASK;
    end
    // Read data for the next cycle, unmapped reads zero
    mn_next.rdata = `RST_BYTE;
    if (i_rd) begin
      unique case (i_addr)
        `OFS_KBC_SOFT_RESET: begin
          mn_next.rdata = mn_reg.soft_reset_ctl;
        end
        `OFS_WAKE_CONTROL: begin
          mn_next.rdata = mn_reg.ctl_misc;
          mn_next.rdata[`BIT_KBD_ISO] = sb_reg.kbd_iso;
          mn_next.rdata[`BIT_MOUSE_ISO] = sb_reg.mouse_iso;
        end
        `OFS_WAKE_STATUS: begin
          mn_next.rdata = sb_reg.wake_status;
        end
        `OFS_WAKE_ENABLE: begin
          mn_next.rdata = sb_reg.wake_enable;
        end
        `OFS_GLOBAL_ENABLE: begin
          mn_next.rdata = {7'h00, sb_reg.global_wake_enable};
        end
        `OFS_IRQ_MASK: begin
          mn_next.rdata = mn_reg.irq_mask;
        end
        default: begin
          mn_next.rdata = `RST_BYTE;
        end
      endcase
    end
  end

  // Main registers, cleared by main reset
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mn_reg <= '0;
      mn_reg.rst_hold <= 1'b1;
    end else begin
      mn_reg <= mn_next;
    end
  end

  // Interrupt select: AND with latch, or latch alone
  always_comb begin
    if (mn_reg.ctl_misc[`BIT_KBD_LATCH_SEL]) begin
      o_kbd_irq = mn_reg.kbd_irq_latch; // R2
    end else begin
      o_kbd_irq = i_kbc_kbd_irq && mn_reg.kbd_irq_latch; // R2
    end
    if (mn_reg.ctl_misc[`BIT_MOUSE_LATCH_SEL]) begin
      o_mouse_irq = mn_reg.mouse_irq_latch; // R1
    end else begin
      o_mouse_irq = i_kbc_mouse_irq && mn_reg.mouse_irq_latch; // R1
    end
  end

  // Lines into the controller read idle high when isolated
  assign o_kbc_kbd_clock = sb_reg.kc_sync[1] || sb_reg.kbd_iso; // R7
  assign o_kbc_kbd_data = sb_reg.kd_sync[1] || sb_reg.kbd_iso; // R7
  assign o_kbc_mouse_clock = sb_reg.mc_sync[1] || sb_reg.mouse_iso; // R6
  assign o_kbc_mouse_data = sb_reg.md_sync[1] || sb_reg.mouse_iso; // R6

  // Controller held in reset by hardware reset or soft bit
  assign o_kbc_reset_n = !mn_reg.rst_hold && !mn_reg.soft_reset_ctl[`BIT_KBC_RESET]; // R9 R15

  // Open-drain pins pull low during reset or on request
  assign o_kbd_clock_line = 1'b0;
  assign o_kbd_data_line = 1'b0;
  assign o_mouse_clock_line = 1'b0;
  assign o_mouse_data_line = 1'b0;
  assign o_kbd_clock_line_oe_n = !(mn_reg.rst_hold || i_kbc_kbd_clock_pull); // R15
  assign o_kbd_data_line_oe_n = !(mn_reg.rst_hold || i_kbc_kbd_data_pull); // R15
  assign o_mouse_clock_line_oe_n = !(mn_reg.rst_hold || i_kbc_mouse_clock_pull); // R15
  assign o_mouse_data_line_oe_n = !(mn_reg.rst_hold || i_kbc_mouse_data_pull); // R15

  // Wake output and software interrupt
  assign wake_active = |(sb_reg.wake_status & sb_reg.wake_enable);
  assign o_wake_event_out_n = !(wake_active && sb_reg.global_wake_enable); // R4
  assign o_irq = |(sb_reg.wake_status & mn_reg.irq_mask);
  assign o_rdata = mn_reg.rdata;

  // Checks on the block's outputs and standby state
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n || !i_standby_reset_n);

  mouse_latch_mux_a: assert property (!mn_reg.ctl_misc[`BIT_MOUSE_LATCH_SEL] |-> // R1
    o_mouse_irq == (i_kbc_mouse_irq && mn_reg.mouse_irq_latch))
    else $error("mouse irq select wrong");
  kbd_latch_mux_a: assert property (mn_reg.ctl_misc[`BIT_KBD_LATCH_SEL] |-> // R2
    o_kbd_irq == mn_reg.kbd_irq_latch)
    else $error("keyboard irq select wrong");
  kbd_data_edge_a: assert property ($fell(sb_reg.kd_sync[1]) |=> // R16
    sb_reg.wake_status[`BIT_WAKE_KBD_DATA])
    else $error("keyboard data edge missed");
  irq_wake_power_a: assert property (!sb_reg.pg_sync[1] && !sb_reg.wake_status[`BIT_WAKE_KBD_IRQ] // R5
    && !wr_status |=> !sb_reg.wake_status[`BIT_WAKE_KBD_IRQ])
    else $error("irq wake without main power");
  wake_gate_a: assert property (!o_wake_event_out_n |-> sb_reg.global_wake_enable // R4
    && |(sb_reg.wake_status & sb_reg.wake_enable))
    else $error("wake asserted without enables");
  mouse_iso_block_a: assert property (sb_reg.mouse_iso |-> // R6
    o_kbc_mouse_clock && o_kbc_mouse_data)
    else $error("mouse lines leak when isolated");
  kbd_iso_block_a: assert property (sb_reg.kbd_iso && !wr_ctl |=> // R7
    o_kbc_kbd_clock && o_kbc_kbd_data)
    else $error("keyboard lines leak when isolated");
  soft_reset_hold_a: assert property (mn_reg.soft_reset_ctl[`BIT_KBC_RESET] // R9
    && !(i_wr && i_addr == `OFS_KBC_SOFT_RESET) |=> !o_kbc_reset_n)
    else $error("controller reset released itself");
  status_sticky_a: assert property ($rose(sb_reg.wake_status[`BIT_WAKE_MOUSE_DATA]) && !wr_status // R3
    |=> sb_reg.wake_status[`BIT_WAKE_MOUSE_DATA])
    else $error("wake status not sticky");

  mouse_wake_c: cover property ($fell(sb_reg.md_sync[1]) ##2 !o_wake_event_out_n);
  kbd_irq_c: cover property (kbd_irq_rise ##1 o_kbd_irq);
  soft_reset_c: cover property (!o_kbc_reset_n ##1 !o_kbc_reset_n ##1 o_kbc_reset_n);

endmodule

//--- kbd_mouse_wake_isolation_tb_top.sv
module kbd_mouse_wake_isolation_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n, sby_n, pg, wr, rd, kirq, mirq, kclr, mclr, kdl, mdl; // Bench drives
  logic [7:0] addr, wdata, rdata; // Register bus
  logic [3:0] pull, oe_n, line, kbc_line, drv; // Pulls, drive enables, pin levels, to controller, drive values
  logic kbc_rst_n, oki, omi, wake_n, irq; // Observed outputs
  logic [31:0] seed = 32'h68ea7056; // Random state
  int err_total = 0, compares = 0, cyc = 0; // Counters
  logic [7:0] exp_q[$]; // Expected reset values of the table below
  logic [7:0] v; // Scratch value
  always #5 clk = ~clk;
  // Device under test
  kbd_mouse_wake_isolation i_dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_standby_reset_n(sby_n),
    .i_main_power_good(pg), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_kbc_kbd_irq(kirq), .i_kbc_mouse_irq(mirq), .i_kbd_irq_clr(kclr), .i_mouse_irq_clr(mclr),
    .o_kbd_irq(oki), .o_mouse_irq(omi), .i_kbc_kbd_clock_pull(pull[0]), .i_kbc_kbd_data_pull(pull[1]),
    .i_kbc_mouse_clock_pull(pull[2]), .i_kbc_mouse_data_pull(pull[3]), .o_kbc_kbd_clock(kbc_line[0]),
    .o_kbc_kbd_data(kbc_line[1]), .o_kbc_mouse_clock(kbc_line[2]), .o_kbc_mouse_data(kbc_line[3]),
    .o_kbc_reset_n(kbc_rst_n), .i_kbd_clock_line(line[0]), .i_kbd_data_line(line[1]),
    .i_mouse_clock_line(line[2]), .i_mouse_data_line(line[3]), .o_kbd_clock_line(drv[0]),
    .o_kbd_clock_line_oe_n(oe_n[0]), .o_kbd_data_line(drv[1]), .o_kbd_data_line_oe_n(oe_n[1]),
    .o_mouse_clock_line(drv[2]), .o_mouse_clock_line_oe_n(oe_n[2]), .o_mouse_data_line(drv[3]),
    .o_mouse_data_line_oe_n(oe_n[3]), .o_wake_event_out_n(wake_n), .o_irq(irq));
  // Far-side devices on the lines
  kbd_mouse_peer i_peer (.i_kbd_data_low(kdl), .i_mouse_data_low(mdl), .i_dut_oe_n(oe_n), .o_line(line));
  // Xorshift source for write data
  function logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Compare and count
  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // One-cycle write strobe
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // One-cycle read strobe, data checked in the following cycle
  task rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp, "read data");
  endtask
  // Let settled outputs be sampled a few cycles on
  task wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Single exit of the run
  task print_verdict();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  // Main sequence
  initial begin
    {rst_n, sby_n, wr, rd, kirq, mirq, kclr, mclr, kdl, mdl} = '0;
    pg = 1'b1; addr = '0; wdata = '0; pull = '0;
    repeat (10) @(posedge clk);
    #1 chk({3'h0, oe_n, kbc_rst_n}, 8'h00, "lines and controller held in reset");
    chk({4'h0, drv}, 8'h00, "pin drive values low");
    @(posedge clk);
    rst_n <= 1'b1; sby_n <= 1'b1;
    wait_cyc(5);
    wr_reg(8'h30, 8'hff);
    exp_q = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    foreach (exp_q[i]) rd_reg(i == 6 ? 8'h55 : (i < 2 ? (i == 0 ? 8'h2c : 8'hf0) : 8'h2e + i[7:0]), exp_q[i]);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      v = 8'(next_rand());
      v[6] = i[0];
      wr_reg(8'h2c, v);
      wait_cyc(2);
      chk({7'h0, kbc_rst_n}, {7'h0, ~v[6]}, "controller reset follows held bit");
      rd_reg(8'h2c, v);
    end
    wr_reg(8'h2c, 8'h40);
    wait_cyc(4);
    chk({7'h0, kbc_rst_n}, 8'h00, "controller reset does not self clear");
    wr_reg(8'h2c, 8'h00);
    $display("test soft reset done");
    for (int s = 0; s < 2; s++) begin
      wr_reg(8'hf0, s == 1 ? 8'h18 : 8'h00);
      kirq <= 1'b1; mirq <= 1'b1;
      wait_cyc(3);
      chk({6'h0, oki, omi}, 8'h03, "irq raw and latched high");
      kirq <= 1'b0; mirq <= 1'b0;
      wait_cyc(1);
      chk({6'h0, oki, omi}, s == 1 ? 8'h03 : 8'h00, "irq after raw drop");
      kclr <= 1'b1; mclr <= 1'b1;
      wait_cyc(1);
      kclr <= 1'b0; mclr <= 1'b0;
      wait_cyc(2);
      chk({6'h0, oki, omi}, 8'h00, "irq after latch clear");
      rd_reg(8'h30, 8'h03);
      wr_reg(8'h30, 8'h03);
    end
    pg <= 1'b0;
    wait_cyc(4);
    kirq <= 1'b1;
    wait_cyc(3);
    rd_reg(8'h30, 8'h00);
    kirq <= 1'b0; pg <= 1'b1;
    wait_cyc(4);
    $display("test irq latch done");
    mirq <= 1'b1;
    wait_cyc(3);
    mirq <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      wr_reg(8'h31, c[0] ? 8'h02 : 8'h00);
      wr_reg(8'h32, {7'h0, c[1]});
      wait_cyc(2);
      chk({7'h0, wake_n}, {7'h0, c != 3}, "wake output versus enables");
    end
    wr_reg(8'h33, 8'h02);
    wait_cyc(2);
    chk({7'h0, irq}, 8'h01, "unmasked status raises irq");
    wr_reg(8'h30, 8'h02);
    wait_cyc(2);
    chk({6'h0, irq, wake_n}, 8'h01, "cleared status drops irq and wake");
    wr_reg(8'h33, 8'h00);
    $display("test wake enable done");
    for (int m = 0; m < 2; m++) begin
      wr_reg(8'hf0, m == 1 ? 8'h60 : 8'h00);
      pull <= 4'hf;
      wait_cyc(5);
      chk({4'h0, kbc_line}, m == 1 ? 8'h0f : 8'h00, "lines into controller");
      rd_reg(8'h30, 8'h18);
      pull <= 4'h0;
      wait_cyc(5);
      chk({4'h0, kbc_line}, 8'h0f, "released lines");
      wr_reg(8'h30, 8'h18);
    end
    $display("test isolation done");
    wr_reg(8'hf0, 8'h78);
    wr_reg(8'h31, 8'h1b);
    @(posedge clk);
    rst_n <= 1'b0;
    wait_cyc(2);
    rst_n <= 1'b1;
    wait_cyc(5);
    wr_reg(8'h30, 8'hff);
    rd_reg(8'hf0, 8'h60);
    rd_reg(8'h31, 8'h1b);
    wr_reg(8'h31, 8'h18);
    pg <= 1'b0;
    mdl <= 1'b1;
    wait_cyc(5);
    rd_reg(8'h30, 8'h10);
    mdl <= 1'b0;
    wait_cyc(4);
    wr_reg(8'h30, 8'hff);
    pg <= 1'b1;
    @(posedge clk);
    sby_n <= 1'b0;
    wait_cyc(2);
    sby_n <= 1'b1;
    wait_cyc(3);
    rd_reg(8'hf0, 8'h00);
    rd_reg(8'h31, 8'h00);
    $display("test standby retention done");
    print_verdict();
  end
endmodule

//--- kbd_wake_map.svh
// Operation
// R1 - mouse irq: raw AND latch, or latch only
// R2 - keyboard irq: raw AND latch, or latch
// R3 - four events set own wake status bits
// R4 - wake needs status, own enable, global enable
// R5 - irq wakes need main power; data always
// R6 - mouse isolation blocks lines into controller
// R7 - keyboard isolation blocks lines into controller
// R8 - isolation bits cleared by standby reset only
// R9 - bit six holds controller reset, no self-clear
// R10 - software resets controller after isolated sleep
// R11 - data line low sets status despite isolation
// R12 - wake enables kept, standby reset clears them
// R13 - software clears data status after power-up
// R14 - software clears enables before main power loss
// R15 - hardware reset drives lines low, clears status; wake status here clears on standby reset only
// R16 - data lines synchronised, falling edge sets bit
`ifndef KBD_WAKE_MAP_SVH
`define KBD_WAKE_MAP_SVH
// Register offsets
`define OFS_KBC_SOFT_RESET 8'h2c
`define OFS_WAKE_CONTROL 8'hf0
`define OFS_WAKE_STATUS 8'h30
`define OFS_WAKE_ENABLE 8'h31
`define OFS_GLOBAL_ENABLE 8'h32
`define OFS_IRQ_MASK 8'h33
// Field positions in the soft reset and control registers
`define BIT_KBC_RESET 6
`define BIT_KBD_LATCH_SEL 3
`define BIT_MOUSE_LATCH_SEL 4
`define BIT_KBD_ISO 5
`define BIT_MOUSE_ISO 6
// Field positions in wake status, enable and mask
`define BIT_WAKE_KBD_IRQ 0
`define BIT_WAKE_MOUSE_IRQ 1
`define BIT_WAKE_KBD_DATA 3
`define BIT_WAKE_MOUSE_DATA 4
`define WAKE_IMPL_MASK 8'h1b
// Reset values
`define RST_BYTE 8'h00
`endif

//--- kbd_wake_pkg.sv
package kbd_wake_pkg;
  // State kept alive on the standby supply
  typedef struct packed {
    logic [1:0] kd_sync; // Keyboard data synchroniser
    logic [1:0] md_sync; // Mouse data synchroniser
    logic [1:0] kc_sync; // Keyboard clock synchroniser
    logic [1:0] mc_sync; // Mouse clock synchroniser
    logic [1:0] pg_sync; // Main power good synchroniser
    logic kd_prev; // Last synced keyboard data
    logic md_prev; // Last synced mouse data
    logic kbd_iso; // Keyboard isolation
    logic mouse_iso; // Mouse isolation
    logic [7:0] wake_status; // Sticky wake status
    logic [7:0] wake_enable; // Per-event wake enables
    logic global_wake_enable; // Global wake enable
  } standby_state_t;
  // State on the main supply
  typedef struct packed {
    logic [7:0] soft_reset_ctl; // Controller soft reset byte
    logic [7:0] ctl_misc; // Other control bits
    logic kbd_irq_latch; // Latched keyboard irq
    logic mouse_irq_latch; // Latched mouse irq
    logic kbd_irq_prev; // Last raw keyboard irq
    logic mouse_irq_prev; // Last raw mouse irq
    logic [7:0] irq_mask; // Interrupt mask
    logic [7:0] rdata; // Read data
    logic rst_hold; // First cycle after reset
  } main_state_t;
endpackage
